// >>> core/gtwsp_pkg.sv
// Package of constants for the gauge two-wire slave port
package gtwsp_pkg;
    localparam int unsigned CLK_HZ            = 10000000;
    // Spike filter width in ns, cycles rounded up
    localparam int unsigned SPIKE_NS          = 50;
    localparam int unsigned SPIKE_CYC_RAW     = (SPIKE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned SPIKE_CYC         = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
    // Bus-low sleep time in seconds
    localparam int unsigned SLEEP_S           = 2;
    localparam int unsigned SLEEP_CYC         = SLEEP_S * CLK_HZ;
    localparam int unsigned MEM_DEPTH         = 256;
    localparam int unsigned MEM_AW            = 8;
    localparam int unsigned USER_BASE         = 8'h20;
    localparam int unsigned USER_BYTES        = 16;
    localparam int unsigned ID_BASE           = 8'h30;
    localparam int unsigned ID_BYTES          = 8;
    localparam logic [7:0]  REG_STATUS        = 8'h00;
    localparam logic [7:0]  REG_CONTROL       = 8'h01;
    localparam logic [7:0]  REG_MEASURE       = 8'h02;
    localparam logic [7:0]  REG_PIN_CFG       = 8'h03;
    localparam logic [7:0]  REG_PIN_IN        = 8'h04;
    localparam logic [6:0]  ADDR_RESET        = 7'h34;
    // Arbitrary identification values, no meaning
    localparam logic [7:0]  FAMILY_DEFAULT    = 8'h5A;
    localparam logic [47:0] SERIAL_DEFAULT    = 48'h0000_0000_0001;
    localparam logic [7:0]  CHECK_DEFAULT     = 8'hA5;
    typedef enum logic [2:0] {
        GTWSP_IDLE, GTWSP_ADDR, GTWSP_ACKA, GTWSP_PTR, GTWSP_WRB, GTWSP_RDB, GTWSP_ACKW, GTWSP_ACKR
    } gtwsp_state_t;
endpackage

// >>> core/gtwsp_mem.sv
// Byte memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module gtwsp_mem
(
    input  wire logic       ref_clk,
    input  wire logic       wrEn,
    input  wire logic [7:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [7:0] rdAddr,
    output logic      [7:0] rdData_ff
);
    logic [7:0] memArray [0:gtwsp_pkg::MEM_DEPTH-1];

    always_ff @(posedge ref_clk)
    begin
        if (wrEn)
        begin
            memArray[wrAddr] <= wrData;
        end
        rdData_ff <= memArray[rdAddr];
    end
endmodule
`default_nettype wire

// >>> core/gtwsp_port.sv
// Two-wire slave port of a fuel gauge
// -----------------------------------------------------------------
// Summary of operation
// R1 - Respond to programmable 7-bit slave address, up to 128 devices.
// R2 - Optional factory 64-bit ID: family, 48-bit serial, check byte.
// R3 - Data line open-drain only: pull low or release.
// R4 - Clock line is input only, never stretched.
// R5 - Master keeps every SCL low shorter than sleep time.
// R6 - Master holds both lines low beyond sleep time to sleep.
// R7 - Filter SDA and SCL spikes up to 50 ns.
// R8 - Sixteen bytes of host storage, unused by the device.
// R9 - Host reads and writes status, control, measurement, storage; here status and measurement are read-only.
// R10 - General-purpose pin is input or open-drain output.
// R11 - Bus-low sleep when enabled and both lines low sleep time.
// R12 - Wake from bus-low sleep when either line goes high.
// R13 - Wake from undervoltage sleep on any line change.
// R14 - Master releases bus, then start-stop-start before talking.
// R15 - Acknowledge only matching address; else ignore until start.
// -----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module gtwsp_port
#(
    parameter int unsigned SLEEP_CYCLES = gtwsp_pkg::SLEEP_CYC,
    parameter bit          ID_FITTED    = 1'b1
)
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic       busLowSleepEnable,
    input  wire logic       undervoltageSleepEnable,
    input  wire logic       cellVoltageLow,
    input  wire logic [6:0] slaveAddr,
    input  wire logic       slaveAddrLoad,
    input  wire logic [7:0] statusIn,
    input  wire logic [7:0] measureIn,
    output logic      [7:0] controlOut,
    input  wire logic       generalPurposePinIn,
    output logic            generalPurposePinOut,
    output logic            generalPurposePinOe,
    output logic            sleeping
);
    // -----------------------------------------------------------------
    // Input synchronisers and spike filters
    // -----------------------------------------------------------------
    logic [1:0] sclSync_ff, sdaSync_ff, gpSync_ff;
    logic [2:0] sclCnt_ff, sdaCnt_ff;
    logic       scl_ff, sda_ff, sclPrev_ff, sdaPrev_ff;
    logic [2:0] nxt_sclCnt, nxt_sdaCnt;
    logic       nxt_scl, nxt_sda;

    always_ff @(posedge ref_clk)
    begin
        sclSync_ff <= {sclSync_ff[0], sclIn};
        sdaSync_ff <= {sdaSync_ff[0], sdaIn};
        gpSync_ff  <= {gpSync_ff[0], generalPurposePinIn};
    end

    // R7 spike filter
    assign nxt_sclCnt = (sclSync_ff[1] == scl_ff) ? 3'h0 : sclCnt_ff + 3'h1;
    assign nxt_sdaCnt = (sdaSync_ff[1] == sda_ff) ? 3'h0 : sdaCnt_ff + 3'h1;
    assign nxt_scl    = (nxt_sclCnt > 3'(gtwsp_pkg::SPIKE_CYC)) ? sclSync_ff[1] : scl_ff;
    assign nxt_sda    = (nxt_sdaCnt > 3'(gtwsp_pkg::SPIKE_CYC)) ? sdaSync_ff[1] : sda_ff;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            sclCnt_ff  <= 3'h0;
            sdaCnt_ff  <= 3'h0;
            scl_ff     <= 1'b1;
            sda_ff     <= 1'b1;
            sclPrev_ff <= 1'b1;
            sdaPrev_ff <= 1'b1;
        end
        else
        begin
            sclCnt_ff  <= (nxt_scl != scl_ff) ? 3'h0 : nxt_sclCnt;
            sdaCnt_ff  <= (nxt_sda != sda_ff) ? 3'h0 : nxt_sdaCnt;
            scl_ff     <= nxt_scl;
            sda_ff     <= nxt_sda;
            sclPrev_ff <= scl_ff;
            sdaPrev_ff <= sda_ff;
        end
    end

    wire sclRise   = scl_ff & ~sclPrev_ff;
    wire sclFall   = ~scl_ff & sclPrev_ff;
    wire startSeen = scl_ff & sclPrev_ff & sdaPrev_ff & ~sda_ff;
    wire stopSeen  = scl_ff & sclPrev_ff & ~sdaPrev_ff & sda_ff;
    wire busLow    = ~scl_ff & ~sda_ff;
    wire busHigh   = scl_ff & sda_ff;
    wire lineMove  = (scl_ff != sclPrev_ff) | (sda_ff != sdaPrev_ff);

    // -----------------------------------------------------------------
    // Sleep control
    // -----------------------------------------------------------------
    logic [31:0] idleCnt_ff;
    logic        sleepBus_ff, sleepUv_ff;
    wire         idleHold  = busLow | (cellVoltageLow & busHigh);
    wire         idleDone  = idleCnt_ff >= (SLEEP_CYCLES - 1);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            idleCnt_ff  <= 32'h0;
            sleepBus_ff <= 1'b0;
            sleepUv_ff  <= 1'b0;
        end
        else
        begin
            idleCnt_ff <= (idleHold && !lineMove && !idleDone) ? idleCnt_ff + 32'h1
                        : (idleHold && !lineMove) ? idleCnt_ff : 32'h0;
            // R11 bus-low entry
            if (busLowSleepEnable && busLow && idleDone && !sleepUv_ff)
                sleepBus_ff <= 1'b1;
            // R12 wake on high
            else if (scl_ff || sda_ff)
                sleepBus_ff <= 1'b0;
            // R13 wake on change; a move beats a stale count
            if (undervoltageSleepEnable && cellVoltageLow && idleDone && !lineMove && !sleepBus_ff)
                sleepUv_ff <= 1'b1;
            else if (lineMove)
                sleepUv_ff <= 1'b0;
        end
    end
    assign sleeping = sleepBus_ff | sleepUv_ff;

    // -----------------------------------------------------------------
    // Byte engine
    // -----------------------------------------------------------------
    gtwsp_pkg::gtwsp_state_t state_ff, nxt_state;
    logic [7:0] shift_ff, ptr_ff, ctrl_ff, gpCfg_ff;
    logic [3:0] bitCnt_ff, nxt_bitCnt;
    logic       rw_ff, ack_ff, sdaLow_ff;
    logic [6:0] addr_ff;
    logic [7:0] memRd;

    // R1 programmable address
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            addr_ff <= gtwsp_pkg::ADDR_RESET;
        else if (slaveAddrLoad)
            addr_ff <= slaveAddr;
    end

    wire       byteDone = sclRise && bitCnt_ff == 4'h7;
    // Acknowledge slot ends at the fall after its own rise
    wire       ackEnd   = sclFall && bitCnt_ff == 4'h1;
    wire [7:0] rxByte   = {shift_ff[6:0], sda_ff};
    // R15 address match
    wire       addrHit  = rxByte[7:1] == addr_ff;
    // R8 storage window
    wire       inUser   = ptr_ff >= 8'(gtwsp_pkg::USER_BASE) &&
                          ptr_ff < 8'(gtwsp_pkg::USER_BASE + gtwsp_pkg::USER_BYTES);
    wire [7:0] idOff    = ptr_ff - 8'(gtwsp_pkg::ID_BASE);
    wire       inId     = ID_FITTED && ptr_ff >= 8'(gtwsp_pkg::ID_BASE) && idOff < 8'(gtwsp_pkg::ID_BYTES);
    // R2 registration number, family first
    wire [63:0] idWord  = {gtwsp_pkg::FAMILY_DEFAULT, gtwsp_pkg::SERIAL_DEFAULT, gtwsp_pkg::CHECK_DEFAULT};
    wire [7:0] idByte   = idWord[8'd63 - {idOff[2:0], 3'h0} -: 8];
    // R9 readable map
    wire [7:0] rdByte   = (ptr_ff == gtwsp_pkg::REG_STATUS)  ? statusIn :
                          (ptr_ff == gtwsp_pkg::REG_CONTROL) ? ctrl_ff :
                          (ptr_ff == gtwsp_pkg::REG_MEASURE) ? measureIn :
                          (ptr_ff == gtwsp_pkg::REG_PIN_CFG) ? gpCfg_ff :
                          (ptr_ff == gtwsp_pkg::REG_PIN_IN)  ? {7'h0, gpSync_ff[1]} : inId ? idByte : memRd;
    wire       memWr    = state_ff == gtwsp_pkg::GTWSP_WRB && byteDone && inUser;

    gtwsp_mem u_mem
    (
        .ref_clk   (ref_clk),
        .wrEn      (memWr),
        .wrAddr    (ptr_ff),
        .wrData    (rxByte),
        .rdAddr    (ptr_ff),
        .rdData_ff (memRd)
    );

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            gtwsp_pkg::GTWSP_IDLE: nxt_state = state_ff;
            gtwsp_pkg::GTWSP_ADDR: if (byteDone) nxt_state = addrHit ? gtwsp_pkg::GTWSP_ACKA : gtwsp_pkg::GTWSP_IDLE;
            gtwsp_pkg::GTWSP_ACKA: if (ackEnd)
                                       nxt_state = rw_ff ? gtwsp_pkg::GTWSP_RDB : gtwsp_pkg::GTWSP_PTR;
            gtwsp_pkg::GTWSP_PTR:  if (byteDone) nxt_state = gtwsp_pkg::GTWSP_ACKW;
            gtwsp_pkg::GTWSP_WRB:  if (byteDone) nxt_state = gtwsp_pkg::GTWSP_ACKW;
            gtwsp_pkg::GTWSP_ACKW: if (ackEnd) nxt_state = gtwsp_pkg::GTWSP_WRB;
            gtwsp_pkg::GTWSP_RDB:  if (sclFall && bitCnt_ff == 4'h8) nxt_state = gtwsp_pkg::GTWSP_ACKR;
            gtwsp_pkg::GTWSP_ACKR: if (sclRise) nxt_state = sda_ff ? gtwsp_pkg::GTWSP_IDLE : gtwsp_pkg::GTWSP_RDB;
        endcase
        if (startSeen)
            nxt_state = gtwsp_pkg::GTWSP_ADDR;
        else if (stopSeen || sleeping)
            nxt_state = gtwsp_pkg::GTWSP_IDLE;
    end

    // Count restarts in every new state so data bit 7 leads
    assign nxt_bitCnt = (startSeen || nxt_state != state_ff) ? 4'h0 : bitCnt_ff + 4'(sclRise);

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            state_ff  <= gtwsp_pkg::GTWSP_IDLE;
            shift_ff  <= 8'h00;
            bitCnt_ff <= 4'h0;
            ptr_ff    <= 8'h00;
            ctrl_ff   <= 8'h00;
            gpCfg_ff  <= 8'h00;
            rw_ff     <= 1'b0;
            sdaLow_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            bitCnt_ff <= nxt_bitCnt;
            if (sclRise)
                shift_ff <= rxByte;
            if (state_ff == gtwsp_pkg::GTWSP_ADDR && byteDone)
                rw_ff <= rxByte[0];
            if (state_ff == gtwsp_pkg::GTWSP_PTR && byteDone)
                ptr_ff <= rxByte;
            if (state_ff == gtwsp_pkg::GTWSP_WRB && byteDone)
            begin
                if (ptr_ff == gtwsp_pkg::REG_CONTROL)
                    ctrl_ff <= rxByte;
                if (ptr_ff == gtwsp_pkg::REG_PIN_CFG)
                    gpCfg_ff <= rxByte;
            end
            // Pointer steps once per data byte, whatever the data
            if ((state_ff == gtwsp_pkg::GTWSP_WRB && byteDone) ||
                (state_ff == gtwsp_pkg::GTWSP_RDB && nxt_state == gtwsp_pkg::GTWSP_ACKR))
                ptr_ff <= ptr_ff + 8'h01;
            // R3 pull low only; change after SCL falls for hold time
            if (sclFall || nxt_state == gtwsp_pkg::GTWSP_IDLE)
                sdaLow_ff <= (nxt_state == gtwsp_pkg::GTWSP_ACKA || nxt_state == gtwsp_pkg::GTWSP_ACKW) ? 1'b1
                           : (nxt_state == gtwsp_pkg::GTWSP_RDB) ? ~rdByte[3'h7 - nxt_bitCnt[2:0]] : 1'b0;
        end
    end

    // R3 open drain, R4 clock never driven
    assign sdaOut = 1'b0;
    assign sdaOe  = sdaLow_ff;
    assign controlOut = ctrl_ff;
    // R10 pin direction bit 0, output level bit 1
    assign generalPurposePinOut = 1'b0;
    assign generalPurposePinOe  = gpCfg_ff[0] & ~gpCfg_ff[1];
endmodule
`default_nettype wire

// >>> bench/gtwsp_port_sva.sv
// Checker on the port's pins and sleep state
`timescale 1ns/10ps
`default_nettype none
module gtwsp_port_sva
#(
    parameter int unsigned SLEEP_CYCLES = 50
)
(
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       busLowSleepEnable,
    input wire logic       undervoltageSleepEnable,
    input wire logic [7:0] controlOut,
    input wire logic       sleeping
);
    // Margin of 8 covers input sync and filter delay
    int unsigned lowCnt_ff;
    always_ff @(posedge ref_clk)
        lowCnt_ff <= (!nrst || !busLowSleepEnable || sclIn || sdaIn) ? 0 : lowCnt_ff + 32'(lowCnt_ff < SLEEP_CYCLES + 8);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    od_data_a: assert property (sdaOe |-> !sdaOut) else $error("data pin driven high");
    rst_state_a: assert property ($rose(nrst) |-> !sdaOe && !sleeping && controlOut == 8'h00) else $error("reset");
    sleep_entry_a: assert property (lowCnt_ff == SLEEP_CYCLES + 8 |-> sleeping) else $error("no sleep");
    sleep_cause_a: assert property ($rose(sleeping) |-> $past(busLowSleepEnable) || $past(undervoltageSleepEnable))
        else $error("sleep without enable");
    sleep_quiet_a: assert property (sleeping && $past(sleeping) |-> !sdaOe) else $error("drive while asleep");
    low_wake_a: assert property (sleeping && !undervoltageSleepEnable && (sclIn || sdaIn) |-> ##[1:8] !sleeping)
        else $error("no wake on high");
    edge_wake_a: assert property (sleeping && $changed(sclIn) |-> ##[1:8] !sleeping) else $error("no wake");
    ack_edge_a: assert property ($changed(sdaOe) |-> !sclIn) else $error("data moved with clock high");
    cover property ($rose(sleeping));
    cover property ($rose(sdaOe));
    cover property ($fell(sleeping) && undervoltageSleepEnable);
endmodule
`default_nettype wire

// >>> bench/gtwsp_master.sv
// Bus master model on the far side of the port
`timescale 1ns/10ps
`default_nettype none
module gtwsp_master
#(
    parameter int HALF = 10
)
(
    input  wire logic       ref_clk,
    input  wire logic       sdaBus,
    output logic            scl = 1'b1,
    output logic            sdaDrv = 1'b1,
    output logic      [7:0] rxByte = 8'h00
);
    event rxDone;
    // every clock low far below sleep time, save the bus-low sleep wave
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // four steps of clock and data levels
    task automatic wave(input logic [7:0] v, input int n);
        for (int k = 3; k >= 0; k--)
        begin
            {scl, sdaDrv} = v[2 * k +: 2];
            tick(n);
        end
    endtask
    // Data moves half a phase after clock falls
    task automatic xfer(input logic [8:0] d, input logic rd);
        logic [8:0] sh;
        for (int i = 8; i >= 0; i--)
        begin
            sdaDrv = d[i];
            tick(HALF);
            scl = 1'b1;
            tick(HALF);
            sh[i] = sdaBus;
            scl = 1'b0;
            tick(HALF / 2);
        end
        rxByte = rd ? sh[8:1] : {7'h00, sh[0]};
        ->rxDone;
    endtask
endmodule
`default_nettype wire

// >>> bench/gtwsp_port_tb.sv
// Self-checking bench for the two-wire slave port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin badCount++; $display("mismatch %s %h %h", nm, e, g); end end
module gtwsp_port_tb;
    localparam int unsigned SLEEP_CYCLES = 50;
    logic       ref_clk = 1'b0, nrst = 1'b0, blEn = 1'b0, undervoltage_sleep_enable = 1'b0, cellLow = 1'b0, ld = 1'b0, gpIn = 1'b0;
    logic       sdaOut, sdaOe, scl, sdaDrv, gpOut, gpOe, sleeping;
    logic [7:0] stat = 8'h00, meas = 8'h00, ctrl, rxByte, model [0:255], expQ [$];
    logic [6:0] addr = 7'h00;
    int         badCount = 0, comparisons = 0, cyc = 0;
    wire        sdaBus = sdaDrv & (sdaOe ? sdaOut : 1'b1);
    always #50 ref_clk = ~ref_clk;
    gtwsp_port #(.SLEEP_CYCLES(SLEEP_CYCLES)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaBus),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .busLowSleepEnable(blEn), .undervoltageSleepEnable(undervoltage_sleep_enable),
        .cellVoltageLow(cellLow), .slaveAddr(addr), .slaveAddrLoad(ld), .statusIn(stat), .measureIn(meas),
        .controlOut(ctrl), .generalPurposePinIn(gpIn), .generalPurposePinOut(gpOut), .generalPurposePinOe(gpOe),
        .sleeping(sleeping));
    gtwsp_master i_mst (.ref_clk(ref_clk), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv), .rxByte(rxByte));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic put(input logic [7:0] e, input logic [8:0] d, input logic rd);
        expQ.push_back(e);
        i_mst.xfer(d, rd);
    endtask
    // Start, address, pointer, then n bytes; ok low expects a refusal
    task automatic acc(input logic [6:0] a, input logic [7:0] p, input int n, input logic rd, input logic ok);
        i_mst.wave(8'h78, 10);
        put({7'h00, ~ok}, {a, 2'b01}, 1'b0);
        if (ok)
        begin
            put(8'h00, {p, 1'b1}, 1'b0);
            if (rd)
                i_mst.wave(8'h78, 10);
            if (rd)
                put(8'h00, {a, 2'b11}, 1'b0);
            for (int i = 0; i < n; i++)
                put(rd ? model[p + i] : 8'h00, rd ? {8'hFF, i == n - 1} : {model[p + i], 1'b1}, rd);
        end
        i_mst.wave(8'h2F, 10);
    endtask
    always @(i_mst.rxDone)
    begin
        logic [7:0] e;
        e = expQ.pop_front();
        `CHK("bus byte", e, rxByte)
    end
    // Run is about 17600 cycles
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            badCount++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(32'hA5579CF7));
        stat = 8'($urandom);
        meas = 8'($urandom);
        gpIn = 1'($urandom);
        for (int i = 0; i < 256; i++)
            model[i] = 8'($urandom);
        model[0] = stat;
        model[2] = meas;
        model[8'h30] = gtwsp_pkg::FAMILY_DEFAULT;
        i_mst.tick(5);
        nrst = 1'b1;
        i_mst.tick(3);
        `CHK("control", 8'h00, ctrl)
        acc(gtwsp_pkg::ADDR_RESET, 8'h01, 1, 1'b0, 1'b1);
        `CHK("control", model[1], ctrl)
        acc(gtwsp_pkg::ADDR_RESET, 8'h00, 3, 1'b1, 1'b1);
        $display("register test done");
        addr = gtwsp_pkg::ADDR_RESET ^ 7'(1 + $urandom_range(126));
        ld = 1'b1;
        i_mst.tick(1);
        ld = 1'b0;
        acc(gtwsp_pkg::ADDR_RESET, 8'h00, 0, 1'b0, 1'b0);
        acc(addr, 8'h20, 16, 1'b0, 1'b1);
        acc(addr, 8'h20, 16, 1'b1, 1'b1);
        acc(addr, 8'h30, 1, 1'b1, 1'b1);
        $display("address and storage test done");
        for (int k = 0; k < 4; k++)
        begin
            model[3] = 8'(k);
            acc(addr, 8'h03, 1, 1'b0, 1'b1);
            `CHK("pin enable", k == 1, gpOe)
            `CHK("pin level", 1'b0, gpOut)
        end
        model[4] = {7'h00, gpIn};
        acc(addr, 8'h03, 2, 1'b1, 1'b1);
        $display("pin test done");
        blEn = 1'b1;
        i_mst.wave(8'h00, SLEEP_CYCLES / 4 + 5);
        `CHK("asleep", 1'b1, sleeping)
        i_mst.wave(8'hFF, 2);
        `CHK("awake", 1'b0, sleeping)
        blEn = 1'b0;
        i_mst.wave(8'h78, 10);
        i_mst.wave(8'h2F, 10);
        acc(addr, 8'h00, 1, 1'b1, 1'b1);
        {undervoltage_sleep_enable, cellLow} = 2'b11;
        i_mst.wave(8'hFF, SLEEP_CYCLES / 4 + 5);
        `CHK("asleep", 1'b1, sleeping)
        i_mst.wave(8'h3F, 2);
        `CHK("awake", 1'b0, sleeping)
        {undervoltage_sleep_enable, cellLow} = 2'b00;
        $display("sleep test done");
        summarize();
    end
endmodule
bind gtwsp_port gtwsp_port_sva #(.SLEEP_CYCLES(SLEEP_CYCLES)) i_sva (.ref_clk(ref_clk), .nrst(nrst), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .busLowSleepEnable(busLowSleepEnable),
    .undervoltageSleepEnable(undervoltageSleepEnable), .controlOut(controlOut), .sleeping(sleeping));
`default_nettype wire
